//--- src/tcu_pkg.sv
package tcu_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] TCU_ADDR_PRIMARY = 8'h17;
	localparam logic [7:0] TCU_ADDR_PULSE = 8'h1b;
	localparam logic [7:0] TCU_ADDR_CONTROL = 8'h2a;
	localparam logic [7:0] TCU_ADDR_IRQ_STATUS = 8'h30;
	localparam logic [7:0] TCU_ADDR_IRQ_MASK = 8'h31;
	localparam logic [7:0] TCU_ADDR_COUNT = 8'h32;
	localparam logic [7:0] TCU_RST_PRIMARY = 8'hff;
	localparam logic [7:0] TCU_RST_PULSE = 8'hff;
	localparam logic [7:0] TCU_RST_CONTROL = 8'h00;
	localparam logic [7:0] TCU_RST_IRQ_MASK = 8'h00;
	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int TCU_BIT_FLIP_FLOP = 7;
	localparam int TCU_CK_HI = 6;
	localparam int TCU_CK_LO = 4;
	localparam int TCU_BIT_START = 3;
	localparam int TCU_MODE_HI = 2;
	localparam int TCU_MODE_LO = 0;
	// status bits: 0 compare match, 1 counter overflow
	localparam int TCU_IRQ_MATCH = 0;
	localparam int TCU_IRQ_OVF = 1;
	// ----------------------------------------
	// clock select and modes
	// ----------------------------------------
	localparam logic [2:0] TCU_CK_FC_DIV11 = 3'h0;
	localparam logic [2:0] TCU_CK_FC_DIV7 = 3'h1;
	localparam logic [2:0] TCU_CK_FC_DIV5 = 3'h2;
	localparam logic [2:0] TCU_CK_FC_DIV3 = 3'h3;
	localparam logic [2:0] TCU_CK_FS = 3'h4;
	localparam logic [2:0] TCU_CK_FC_DIV1 = 3'h5;
	localparam logic [2:0] TCU_CK_FC = 3'h6;
	localparam logic [2:0] TCU_CK_NONE = 3'h7;
	typedef enum logic [2:0] {
		TCU_M_TIMER8 = 3'b000,
		TCU_M_DIVIDER8 = 3'b001,
		TCU_M_PWM8 = 3'b010,
		TCU_M_RESERVED = 3'b011,
		TCU_M_TIMER16 = 3'b100,
		TCU_M_WARMUP = 3'b101,
		TCU_M_PWM16 = 3'b110,
		TCU_M_PULSEGEN16 = 3'b111
	} tcu_mode_e;
	localparam int TCU_PRESCALE_W = 11;
	localparam int TCU_FS_PRESCALE_W = 3;
endpackage

//--- src/tcu_tick_if.sv
`timescale 1ns/10ps
// ----------------------------------------
// tick interface between selector and core
// ----------------------------------------
interface tcu_tick_if;
	logic [2:0] clock_select;
	logic divider_clock_option;
	logic slow_mode;
	logic tick;
	logic valid_sel;
	modport sel(input clock_select, input divider_clock_option, input slow_mode,
		output tick, output valid_sel);
	modport core(output clock_select, output divider_clock_option, output slow_mode,
		input tick, input valid_sel);
endinterface

//--- src/tcu_clock_sel.sv
`timescale 1ns/10ps
module tcu_clock_sel
	import tcu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic fc_tick,
	input wire logic fs_tick,
	tcu_tick_if.sel tk
);
	// ----------------------------------------
	// prescalers
	// ----------------------------------------
	logic [TCU_PRESCALE_W-1:0] fc_cnt_r;
	logic [TCU_FS_PRESCALE_W-1:0] fs_cnt_r;
	logic [TCU_PRESCALE_W-1:0] fc_cnt_nxt;
	logic [TCU_FS_PRESCALE_W-1:0] fs_cnt_nxt;
	logic fc_d1, fc_d3, fc_d5, fc_d7, fc_d11, fs_d3;
	logic tick_raw;

	// a tap fires when its low bits roll over on a source tick
	assign fc_cnt_nxt = fc_cnt_r + TCU_PRESCALE_W'(1);
	assign fs_cnt_nxt = fs_cnt_r + TCU_FS_PRESCALE_W'(1);
	assign fc_d1 = fc_tick & fc_cnt_r[0];
	assign fc_d3 = fc_tick & (&fc_cnt_r[2:0]);
	assign fc_d5 = fc_tick & (&fc_cnt_r[4:0]);
	assign fc_d7 = fc_tick & (&fc_cnt_r[6:0]);
	assign fc_d11 = fc_tick & (&fc_cnt_r);
	assign fs_d3 = fs_tick & (&fs_cnt_r);

	// prescalers run free so divided ticks keep their phase
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fc_cnt_r <= '0;
			fs_cnt_r <= '0;
		end else begin
			if (fc_tick) fc_cnt_r <= fc_cnt_nxt;
			if (fs_tick) fs_cnt_r <= fs_cnt_nxt;
		end
	end

	// source select; slow mode leaves only 000 and 100
	always_comb begin
		tick_raw = 1'b0;
		unique case (tk.clock_select)
			TCU_CK_FC_DIV11: tick_raw = (tk.divider_clock_option | tk.slow_mode) ? fs_d3 : fc_d11;
			TCU_CK_FC_DIV7: tick_raw = fc_d7 & ~tk.slow_mode;
			TCU_CK_FC_DIV5: tick_raw = fc_d5 & ~tk.slow_mode;
			TCU_CK_FC_DIV3: tick_raw = fc_d3 & ~tk.slow_mode;
			TCU_CK_FS: tick_raw = fs_tick;
			TCU_CK_FC_DIV1: tick_raw = fc_d1 & ~tk.slow_mode;
			TCU_CK_FC: tick_raw = fc_tick & ~tk.slow_mode;
			TCU_CK_NONE: tick_raw = 1'b0;
		endcase
	end
	assign tk.tick = tick_raw;
	assign tk.valid_sel = (tk.clock_select != TCU_CK_NONE);
endmodule

//--- src/tcu_upper_unit.sv
`timescale 1ns/10ps
module tcu_upper_unit
	import tcu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic fc_tick,
	input wire logic fs_tick,
	input wire logic divider_clock_option,
	input wire logic slow_mode,
	input wire logic lower_overflow,
	output logic compare_match_interrupt,
	output logic flip_flop_out,
	output logic [7:0] count_out,
	output logic irq
);
	// ----------------------------------------
	// registers and bus decode
	// ----------------------------------------
	logic [7:0] primary_r;
	logic [7:0] pulse_r;
	logic [7:0] control_r;
	logic [1:0] irq_status_r;
	logic [1:0] irq_mask_r;
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic match_pulse_r;
	logic ff_r;
	logic start_d_r;
	logic wr_primary, wr_pulse, wr_control, wr_status, wr_mask;
	logic upper_start_bit, flip_flop_control, cascade;
	logic [2:0] upper_clock_select;
	tcu_mode_e upper_mode_field;
	logic run, mode_ok, step, at_match, start_rise;
	logic [1:0] events;
	tcu_tick_if tk();

	assign wr_primary = reg_wr & (reg_addr == TCU_ADDR_PRIMARY);
	assign wr_pulse = reg_wr & (reg_addr == TCU_ADDR_PULSE);
	assign wr_control = reg_wr & (reg_addr == TCU_ADDR_CONTROL);
	assign wr_status = reg_wr & (reg_addr == TCU_ADDR_IRQ_STATUS);
	assign wr_mask = reg_wr & (reg_addr == TCU_ADDR_IRQ_MASK);

	// field split of the control register
	assign flip_flop_control = control_r[TCU_BIT_FLIP_FLOP];
	assign upper_clock_select = control_r[TCU_CK_HI:TCU_CK_LO];
	assign upper_start_bit = control_r[TCU_BIT_START];
	assign upper_mode_field = tcu_mode_e'(control_r[TCU_MODE_HI:TCU_MODE_LO]);

	// compare and control storage; writes land unconditionally, software keeps the
	// running-write restrictions itself
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			primary_r <= TCU_RST_PRIMARY;
			pulse_r <= TCU_RST_PULSE;
			control_r <= TCU_RST_CONTROL;
			irq_mask_r <= TCU_RST_IRQ_MASK[1:0];
		end else begin
			if (wr_primary) primary_r <= reg_wdata;
			if (wr_pulse) pulse_r <= reg_wdata;
			if (wr_control) control_r <= reg_wdata;
			if (wr_mask) irq_mask_r <= reg_wdata[1:0];
		end
	end

	// read mux; unmapped addresses read zero, data stand one cycle later
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr)
			TCU_ADDR_PRIMARY: rdata_nxt = primary_r;
			TCU_ADDR_PULSE: rdata_nxt = pulse_r;
			TCU_ADDR_CONTROL: rdata_nxt = control_r;
			TCU_ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
			TCU_ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
			TCU_ADDR_COUNT: rdata_nxt = count_r;
			default: rdata_nxt = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) rdata_r <= 8'h00;
		else rdata_r <= reg_rd ? rdata_nxt : 8'h00;
	end
	assign reg_rdata = rdata_r;

	// ----------------------------------------
	// source clock
	// ----------------------------------------
	assign tk.clock_select = upper_clock_select;
	assign tk.divider_clock_option = divider_clock_option;
	assign tk.slow_mode = slow_mode;
	tcu_clock_sel u_sel (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.fc_tick(fc_tick),
		.fs_tick(fs_tick),
		.tk(tk)
	);

	// the step that would reach the primary value clears instead; used for the count clear and the match pulse
	function automatic logic hits_primary(input logic [7:0] cnt, input logic [7:0] cmp);
		return (cnt + 8'h01) == cmp;
	endfunction

	// cascade takes the lower overflow and ignores own select
	assign cascade = upper_mode_field[2];
	assign mode_ok = (upper_mode_field != TCU_M_RESERVED) & (cascade | tk.valid_sel);
	assign run = upper_start_bit & mode_ok;
	assign step = run & (cascade ? lower_overflow : tk.tick);
	assign at_match = hits_primary(count_r, primary_r);

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// match clears the count on the step that would reach it
	always_comb begin
		count_nxt = count_r;
		if (!upper_start_bit) count_nxt = 8'h00;
		else if (step) begin
			if (!cascade && at_match) count_nxt = 8'h00;
			else count_nxt = count_r + 8'h01;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) count_r <= 8'h00;
		else count_r <= count_nxt;
	end
	assign count_out = count_r;

	// one-cycle match pulse in 8-bit modes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) match_pulse_r <= 1'b0;
		else match_pulse_r <= step & ~cascade & at_match;
	end
	assign compare_match_interrupt = match_pulse_r;

	// timer flip-flop loads its control value while stopped; toggles on match in divider mode
	always_ff @(posedge clk_sys) begin
		if (!rst_n) ff_r <= 1'b0;
		else if (!upper_start_bit) ff_r <= flip_flop_control;
		else if (match_pulse_r && upper_mode_field == TCU_M_DIVIDER8) ff_r <= ~ff_r;
	end
	assign flip_flop_out = ff_r;

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	// set wins over a write-one clear in the same cycle
	assign events = {step & cascade & (count_r == 8'hff), match_pulse_r};
	always_ff @(posedge clk_sys) begin
		if (!rst_n) irq_status_r <= 2'b00;
		else irq_status_r <= events | (irq_status_r & ~(wr_status ? reg_wdata[1:0] : 2'b00));
	end
	assign irq = |(irq_status_r & irq_mask_r);

	// previous start level, kept only so the start cover sees a clean edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) start_d_r <= 1'b0;
		else start_d_r <= upper_start_bit;
	end
	assign start_rise = upper_start_bit & ~start_d_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_stop_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!upper_start_bit |=> count_r == 8'h00)
		else $error("counter not cleared while stopped");
	a_match_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(step && !cascade && (count_r + 8'h01) == primary_r) |=> compare_match_interrupt
		&& count_r == 8'h00)
		else $error("match did not interrupt and clear");
	a_reserved_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_mode_field == TCU_M_RESERVED && upper_start_bit) |=> $stable(count_r))
		else $error("reserved mode counted");
	a_cascade_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cascade && upper_start_bit && !lower_overflow) |=> $stable(count_r))
		else $error("cascade counted without lower overflow");
	a_cascade_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cascade && upper_start_bit && lower_overflow) |=> count_r == $past(count_r) + 8'h01)
		else $error("cascade missed lower overflow");
	a_reset_primary: assert property (@(posedge clk_sys)
		!rst_n |=> primary_r == 8'hff && pulse_r == 8'hff)
		else $error("compare reset value wrong");
	a_reset_control: assert property (@(posedge clk_sys)
		!rst_n |=> control_r == 8'h00)
		else $error("control reset value wrong");
	a_slow_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(slow_mode && upper_clock_select == TCU_CK_FC_DIV3) |-> !tk.tick)
		else $error("fast clock passed in slow mode");
	a_write_one_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_status && reg_wdata[0] && !match_pulse_r) |=> !irq_status_r[0])
		else $error("status bit not cleared");

	// ----------------------------------------
	// register bus assertions
	// ----------------------------------------
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_read_primary: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_rd && reg_addr == TCU_ADDR_PRIMARY) |=> reg_rdata == $past(primary_r))
		else $error("primary compare read wrong");
	a_read_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_rd && reg_addr == TCU_ADDR_PULSE) |=> reg_rdata == $past(pulse_r))
		else $error("pulse width read wrong");
	a_read_control: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_rd && reg_addr == TCU_ADDR_CONTROL) |=> reg_rdata == $past(control_r))
		else $error("control read wrong");
	a_read_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_rd && reg_addr == TCU_ADDR_COUNT) |=> reg_rdata == $past(count_r))
		else $error("count read wrong");
	a_read_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_rd && reg_addr == TCU_ADDR_IRQ_STATUS) |=> reg_rdata == {6'h00, $past(irq_status_r)})
		else $error("status read wrong");
	a_write_primary: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_primary |=> primary_r == $past(reg_wdata))
		else $error("primary compare write lost");
	a_write_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_pulse |=> pulse_r == $past(reg_wdata))
		else $error("pulse width write lost");
	a_write_control: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_control |=> control_r == $past(reg_wdata))
		else $error("control write lost");
	a_write_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_mask |=> irq_mask_r == $past(reg_wdata[1:0]))
		else $error("mask write lost");

	// ----------------------------------------
	// counter and flip-flop assertions
	// ----------------------------------------
	a_hold_no_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_start_bit && !step) |=> $stable(count_r))
		else $error("counter moved without a step");
	a_timer_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(step && !cascade && (count_r + 8'h01) != primary_r) |=> count_r == $past(count_r) + 8'h01)
		else $error("timer step did not count up");
	a_idle_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!cascade && upper_clock_select == TCU_CK_NONE && upper_start_bit) |=> $stable(count_r))
		else $error("unsupported select counted");
	a_cascade_no_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cascade |=> !compare_match_interrupt)
		else $error("match pulse in cascade mode");
	a_divider_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_start_bit && match_pulse_r && upper_mode_field == TCU_M_DIVIDER8)
		|=> flip_flop_out != $past(flip_flop_out))
		else $error("divider output did not toggle");
	a_timer_ff_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_start_bit && upper_mode_field == TCU_M_TIMER8) |=> $stable(flip_flop_out))
		else $error("flip-flop moved in timer mode");
	a_stopped_ff_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!upper_start_bit |=> flip_flop_out == $past(flip_flop_control))
		else $error("flip-flop not loaded while stopped");
	a_reset_outputs: assert property (@(posedge clk_sys)
		!rst_n |=> count_r == 8'h00 && reg_rdata == 8'h00
		&& !compare_match_interrupt && !irq)
		else $error("outputs not cleared by reset");

	// ----------------------------------------
	// select and flag assertions
	// ----------------------------------------
	a_fs_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		upper_clock_select == TCU_CK_FS |-> tk.tick == fs_tick)
		else $error("fs select passed wrong tick");
	a_fc_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(upper_clock_select == TCU_CK_FC && !slow_mode) |-> tk.tick == fc_tick)
		else $error("fc select passed wrong tick");
	a_slow_fc_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(slow_mode && upper_clock_select == TCU_CK_FC) |-> !tk.tick)
		else $error("fc passed in slow mode");
	a_ovf_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		events[TCU_IRQ_OVF] |=> irq_status_r[TCU_IRQ_OVF])
		else $error("overflow status not set");
	a_match_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		compare_match_interrupt |=> irq_status_r[TCU_IRQ_MATCH])
		else $error("match status not set");
	a_status_clear_ovf: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_status && reg_wdata[TCU_IRQ_OVF] && !events[TCU_IRQ_OVF])
		|=> !irq_status_r[TCU_IRQ_OVF])
		else $error("overflow status not cleared");

	// ----------------------------------------
	// covers of the main scenarios
	// ----------------------------------------
	c_match: cover property (@(posedge clk_sys) disable iff (!rst_n) compare_match_interrupt);
	c_cascade: cover property (@(posedge clk_sys) disable iff (!rst_n) events[TCU_IRQ_OVF]);
	c_start: cover property (@(posedge clk_sys) disable iff (!rst_n) start_rise);
	c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) irq);
	c_divider: cover property (@(posedge clk_sys) disable iff (!rst_n)
		compare_match_interrupt && upper_mode_field == TCU_M_DIVIDER8);
endmodule

//--- sim/test_timer_counter_upper_unit_regs.sv
`timescale 1ns/10ps
module test_timer_counter_upper_unit_regs;
	import tcu_pkg::*;
	// ----------------------------------------
	// stimulus and design
	// ----------------------------------------
	logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, fc_tick = 0, fs_tick = 0;
	logic divider_clock_option = 0, slow_mode = 0, lower_overflow = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, rd_v, cr = 0, d;
	wire logic [7:0] reg_rdata, count_out;
	wire logic compare_match_interrupt, flip_flop_out, irq;
	int num_errors = 0, n_tests = 0, cyc = 0, n, k, pri;
	tcu_upper_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fc_tick(fc_tick), .fs_tick(fs_tick), .divider_clock_option(divider_clock_option),
		.slow_mode(slow_mode), .lower_overflow(lower_overflow),
		.compare_match_interrupt(compare_match_interrupt), .flip_flop_out(flip_flop_out),
		.count_out(count_out), .irq(irq));
	always #5 clk_sys = ~clk_sys;
	// hang guard, well above the slowest divider run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task test_done();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	// data stand only in the cycle after the strobe edge
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	function automatic logic [7:0] ctl(input logic [2:0] sel, input logic st, input logic [2:0] m);
		return {1'b0, sel, st, m};
	endfunction
	// cycles between matches when every fc and fs tick is present
	function automatic int per(input logic [2:0] sel, input int p);
		int sh[8] = '{11, 7, 5, 3, 0, 1, 0, 0};
		if (sel == TCU_CK_FC_DIV11 && (divider_clock_option || slow_mode))
			return p * 8;
		return p << sh[sel];
	endfunction
	// stop keeps the other fields, as a stop transition must not change them
	task stop();
		cr = cr & 8'hf7;
		wr(TCU_ADDR_CONTROL, cr);
	endtask
	task wmatch(output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			#1 c++;
		end while (compare_match_interrupt !== 1'b1 && c < 10000);
	endtask
	task meas(input logic [2:0] sel);
		stop();
		cr = ctl(sel, 1'b1, TCU_M_TIMER8);
		wr(TCU_ADDR_CONTROL, cr);
		wmatch(n);
		chk("match pulse", compare_match_interrupt, 1'b1);
		chk("count at match", count_out, 16'h0);
		wmatch(n);
		chk("match period", 16'(n), 16'(per(sel, pri)));
	endtask
	task idle(input logic [2:0] sel, input logic [2:0] m);
		stop();
		cr = ctl(sel, 1'b1, m);
		wr(TCU_ADDR_CONTROL, cr);
		repeat (40) @(posedge clk_sys);
		#1 chk("idle count", count_out, 16'h0);
		stop();
	endtask
	task pulses(input int c);
		repeat (c) begin
			@(posedge clk_sys);
			lower_overflow <= 1;
			@(posedge clk_sys);
			lower_overflow <= 0;
		end
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(82));
		repeat (5) @(posedge clk_sys);
		rst_n <= 1;
		fc_tick <= 1;
		fs_tick <= 1;
		rd(TCU_ADDR_PRIMARY, rd_v);
		chk("primary reset", rd_v, 16'hff);
		rd(TCU_ADDR_PULSE, rd_v);
		chk("pulse reset", rd_v, 16'hff);
		rd(TCU_ADDR_CONTROL, rd_v);
		chk("control reset", rd_v, 16'h00);
		rd(8'h40, rd_v);
		chk("unmapped read", rd_v, 16'h00);
		// random read-back while stopped; start bit kept low
		for (int i = 0; i < 3; i++) begin
			d = 8'($urandom);
			if (i == 2)
				d = d & 8'hf7;
			wr(i == 0 ? TCU_ADDR_PRIMARY : i == 1 ? TCU_ADDR_PULSE : TCU_ADDR_CONTROL, d);
			rd(i == 0 ? TCU_ADDR_PRIMARY : i == 1 ? TCU_ADDR_PULSE : TCU_ADDR_CONTROL, rd_v);
			chk("read back", rd_v, d);
		end
		repeat (2) @(posedge clk_sys);
		#1 chk("flip-flop follows bit7", flip_flop_out, d[7]);
		cr = d;
		pri = 1 + $urandom % 3;
		wr(TCU_ADDR_PRIMARY, 8'(pri));
		for (int s = 0; s < 7; s++)
			meas(3'(s));
		@(posedge clk_sys);
		divider_clock_option <= 1;
		meas(TCU_CK_FC_DIV11);
		@(posedge clk_sys);
		slow_mode <= 1;
		meas(TCU_CK_FS);
		meas(TCU_CK_FC_DIV11);
		idle(TCU_CK_FC_DIV7, TCU_M_TIMER8);
		@(posedge clk_sys);
		slow_mode <= 0;
		divider_clock_option <= 0;
		idle(TCU_CK_NONE, TCU_M_TIMER8);
		idle(TCU_CK_FC, TCU_M_RESERVED);
		// divider mode: the flip-flop inverts once after every match pulse
		cr = ctl(TCU_CK_FC, 1'b1, TCU_M_DIVIDER8);
		wr(TCU_ADDR_CONTROL, cr);
		repeat (2) begin
			wmatch(n);
			d[0] = flip_flop_out;
			@(posedge clk_sys);
			#1 chk("divider toggle", flip_flop_out, !d[0]);
		end
		stop();
		// interrupt: sticky match bit, masked, unmasked, cleared
		#1 chk("irq masked", irq, 1'b0);
		rd(TCU_ADDR_IRQ_STATUS, rd_v);
		chk("match status", rd_v[TCU_IRQ_MATCH], 1'b1);
		wr(TCU_ADDR_IRQ_MASK, 8'h01);
		#1 chk("irq unmasked", irq, 1'b1);
		wr(TCU_ADDR_IRQ_STATUS, 8'h01);
		#1 chk("irq cleared", irq, 1'b0);
		// cascade: lower unit taken as set to cascade, own fast select ignored
		cr = ctl(TCU_CK_FC, 1'b1, TCU_M_TIMER16);
		wr(TCU_ADDR_CONTROL, cr);
		repeat (20) @(posedge clk_sys);
		#1 chk("cascade ignores select", count_out, 16'h0);
		k = 1 + $urandom % 200;
		pulses(k);
		chk("cascade count", count_out, 16'(k));
		wr(TCU_ADDR_IRQ_MASK, 8'h03);
		pulses(256 - k);
		chk("cascade wrap", count_out, 16'h0);
		rd(TCU_ADDR_IRQ_STATUS, rd_v);
		chk("overflow status", rd_v, 16'h02);
		chk("irq overflow", irq, 1'b1);
		pulses(5);
		stop();
		repeat (2) @(posedge clk_sys);
		#1 chk("stop clears count", count_out, 16'h0);
		test_done();
	end
endmodule
